// File: rtl/lin_sync_pkg.sv
// Constants, register map and fields of the LIN break/sync timing unit
// Behaviour
// - Unit works as LIN slave only, bus rates from 1 to 20 kbaud.
// - Break timer ticks from low-power oscillator; sync timing uses 5 MHz.
// - Reading the sync status register clears every flag in it.
// - In bit-serial-device mode a bus rising edge sets status bit 6.
// - Status bit 5 is set when a commanded unit reset completes.
// - 12-bit break timer overflow sets bit 4 and raises the interrupt.
// - Bit 3 is set when sync bit timer equals the compare value.
// - Bit 2 is set when the sync measurement stop condition is seen.
// - Bit 1 is set when the sync measurement start condition is seen.
// - Bit 0 is set when the break timer reaches the break compare value.
// - A 16-bit sync timer is run under the first control register.
// - Edge control register selects the start and stop edges of counting.
// - Control bit 12 gates rise interrupt: disables in bit-serial, enables in LIN.
`default_nettype none
package lin_sync_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_SYNC_STATUS   = 32'hFFFF_0780;
  localparam logic [31:0] ADDR_SYNC_CTRL     = 32'hFFFF_0784;
  localparam logic [31:0] ADDR_EDGE_CTRL     = 32'hFFFF_0788;
  localparam logic [31:0] ADDR_SYNC_TIMER    = 32'hFFFF_078C;
  localparam logic [31:0] ADDR_BREAK_TIMER   = 32'hFFFF_0790;
  localparam logic [31:0] ADDR_BREAK_COMPARE = 32'hFFFF_0794;
  localparam logic [31:0] ADDR_SYNC_COMPARE  = 32'hFFFF_0798;
  localparam logic [31:0] ADDR_IRQ_STATUS    = 32'hFFFF_079C;
  localparam logic [31:0] ADDR_IRQ_MASK      = 32'hFFFF_07A0;

  // Status bit positions
  localparam int ST_BREAK = 0;
  localparam int ST_START = 1;
  localparam int ST_STOP  = 2;
  localparam int ST_CMP   = 3;
  localparam int ST_BERR  = 4;
  localparam int ST_RST   = 5;
  localparam int ST_RISE  = 6;
  localparam int EVT_W    = 7;

  // Control fields
  localparam int CTL_EN       = 0;
  localparam int CTL_RST      = 1;
  localparam int CTL_SERIAL   = 2;
  localparam int CTL_RISE_IRQ = 12;
  localparam logic [31:0] CTL_WR_MASK = 32'h0000_1005;
  localparam logic [31:0] CTL_RESET   = 32'h0000_0000;

  // Edge control fields: 0 selects falling, 1 rising
  localparam int EDG_START   = 0;
  localparam int EDG_STOP    = 1;
  localparam int EDG_CNT_LSB = 4;
  localparam int EDG_CNT_W   = 4;
  localparam logic [31:0] EDG_WR_MASK = 32'h0000_00F3;
  localparam logic [31:0] EDG_RESET   = 32'h0000_0040;

  // Timers and reset values
  localparam int BRK_W  = 12;
  localparam int SYNC_W = 16;
  localparam logic [BRK_W-1:0]  BRK_MAX        = 12'hFFF;
  localparam logic [BRK_W-1:0]  BRK_CMP_RESET  = 12'h0FF;
  localparam logic [SYNC_W-1:0] SYNC_CMP_RESET = 16'hFFFF;
  localparam logic [31:0]       STATUS_RESET   = 32'h0000_0000;

  // Clock rates and derived dividers
  localparam int CLK_HZ      = 40_000_000;
  localparam int SYNC_CLK_HZ = 5_000_000;
  localparam int LP_OSC_HZ   = 131_072;
  localparam int SYNC_DIV    = CLK_HZ / SYNC_CLK_HZ;
  localparam int LP_DIV      = CLK_HZ / LP_OSC_HZ;
  localparam int MIN_BAUD    = 1_000;
  localparam int MAX_BAUD    = 20_000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {SY_IDLE, SY_ARMED, SY_COUNT} sync_state_t;

endpackage
`default_nettype wire

// File: rtl/lin_tick_gen.sv
// Divider producing a one-cycle timebase tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module lin_tick_gen #(
  parameter int unsigned DIV = 8
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick out
  output var  logic tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb
  begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// File: rtl/lin_edge_detect.sv
// Bus level register with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module lin_edge_detect (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bus level
  input  wire logic rx,
  // Edge results
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);
  logic lvl_q;
  logic rise_q;
  logic fall_q;
  logic rise_d;
  logic fall_d;

  always_comb
  begin
    rise_d = rx & ~lvl_q;
    fall_d = ~rx & lvl_q;
  end

  // Idle bus is recessive high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lvl_q  <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      lvl_q  <= rx;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level = lvl_q;
  assign rise  = rise_q;
  assign fall  = fall_q;
endmodule
`default_nettype wire

// File: rtl/lin_hw_sync.sv
// LIN slave break and sync-byte timing unit with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module lin_hw_sync
  import lin_sync_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // LIN bus receive level, slave only
  input  wire logic        lin_rx,
  // Interrupt
  output var  logic        irq
);

  function automatic logic is_mapped(input logic [31:0] a);
    return a inside {ADDR_SYNC_STATUS, ADDR_SYNC_CTRL, ADDR_EDGE_CTRL,
                     ADDR_SYNC_TIMER, ADDR_BREAK_TIMER, ADDR_BREAK_COMPARE,
                     ADDR_SYNC_COMPARE, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // Timebases and bus edges
  logic sync_tick;
  logic lp_tick;
  logic rx_lvl;
  logic rx_rise;
  logic rx_fall;

  lin_tick_gen #(.DIV(SYNC_DIV)) u_sync_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (sync_tick)
  );
  lin_tick_gen #(.DIV(LP_DIV)) u_lp_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (lp_tick)
  );
  // receive only, never drives the bus
  lin_edge_detect u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx      (lin_rx),
    .level   (rx_lvl),
    .rise    (rx_rise),
    .fall    (rx_fall)
  );

  // Bus group
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] wa_q, wa_d, wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0]  ws_q, ws_d;
  logic        do_write, rd_hs, rd_status;

  // Register group
  logic [31:0]       ctl_q, ctl_d, edg_q, edg_d;
  logic [BRK_W-1:0]  bcmp_q, bcmp_d;
  logic [SYNC_W-1:0] scmp_q, scmp_d;
  logic [EVT_W-1:0]  sta_q, sta_d, ist_q, ist_d, imsk_q, imsk_d;
  logic              rst_pend_q, rst_pend_d, irq_q, irq_d;

  // Core group
  logic [BRK_W-1:0]  brk_q, brk_d;
  logic              brk_hit_q, brk_hit_d, brk_ovf_q, brk_ovf_d;
  logic [SYNC_W-1:0] stm_q, stm_d;
  logic [EDG_CNT_W-1:0] ecnt_q, ecnt_d;
  sync_state_t       sst_q, sst_d;
  logic [EVT_W-1:0]  evt, irq_evt;
  logic              rise_en, start_edge, stop_edge;

  always_comb
  begin
    do_write  = aw_have_q & w_have_q & ~bvalid_q;
    rd_hs     = arvalid & arready_q;
    rd_status = rd_hs & (araddr == ADDR_SYNC_STATUS);
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (awvalid & awready_q)
    begin
      aw_have_d = 1'b1;
      awready_d = 1'b0;
      wa_d      = awaddr;
    end
    if (wvalid & wready_q)
    begin
      w_have_d = 1'b1;
      wready_d = 1'b0;
      wd_d     = wdata;
      ws_d     = wstrb;
    end
    if (do_write)
    begin
      bvalid_d  = 1'b1;
      bresp_d   = is_mapped(wa_q) ? RESP_OKAY : RESP_SLVERR;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
    end
    if (bvalid_q & bready)
    begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    if (rd_hs)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        ADDR_SYNC_STATUS:   rdata_d = {25'h0, sta_q};
        ADDR_SYNC_CTRL:     rdata_d = ctl_q;
        ADDR_EDGE_CTRL:     rdata_d = edg_q;
        ADDR_SYNC_TIMER:    rdata_d = {16'h0, stm_q};
        ADDR_BREAK_TIMER:   rdata_d = {20'h0, brk_q};
        ADDR_BREAK_COMPARE: rdata_d = {20'h0, bcmp_q};
        ADDR_SYNC_COMPARE:  rdata_d = {16'h0, scmp_q};
        ADDR_IRQ_STATUS:    rdata_d = {25'h0, ist_q};
        ADDR_IRQ_MASK:      rdata_d = {25'h0, imsk_q};
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
    if (rvalid_q & rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      wa_q      <= 32'h0000_0000;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      wa_q      <= wa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Timers and sync measurement
  always_comb
  begin
    brk_d      = brk_q;
    brk_hit_d  = brk_hit_q;
    brk_ovf_d  = brk_ovf_q;
    stm_d      = stm_q;
    ecnt_d     = ecnt_q;
    sst_d      = sst_q;
    evt        = '0;
    start_edge = edg_q[EDG_START] ? rx_rise : rx_fall;
    stop_edge  = edg_q[EDG_STOP] ? rx_rise : rx_fall;
    rise_en    = ctl_q[CTL_SERIAL] ? ~ctl_q[CTL_RISE_IRQ]
                                   : ctl_q[CTL_RISE_IRQ];
    if (rst_pend_q)
    begin
      brk_d     = '0;
      brk_hit_d = 1'b0;
      brk_ovf_d = 1'b0;
      stm_d     = '0;
      ecnt_d    = '0;
      sst_d     = SY_IDLE;
      evt[ST_RST] = 1'b1;
    end
    else if (ctl_q[CTL_EN])
    begin
      if (!rx_lvl)
      begin
        if ((brk_q == bcmp_q) && !brk_hit_q)
        begin
          brk_hit_d     = 1'b1;
          evt[ST_BREAK] = 1'b1;
          sst_d         = SY_ARMED;
          ecnt_d        = '0;
        end
        // overflow means bus low too long
        if (lp_tick && !brk_ovf_q)
        begin
          if (brk_q == BRK_MAX)
          begin
            brk_ovf_d    = 1'b1;
            evt[ST_BERR] = 1'b1;
          end
          else
            brk_d = brk_q + BRK_W'(1);
        end
      end
      else
      begin
        brk_d     = '0;
        brk_hit_d = 1'b0;
        brk_ovf_d = 1'b0;
      end
      unique case (sst_q)
        SY_IDLE: ;
        SY_ARMED:
          if (start_edge)
          begin
            evt[ST_START] = 1'b1;
            stm_d         = '0;
            ecnt_d        = '0;
            sst_d         = SY_COUNT;
          end
        SY_COUNT:
        begin
          if (sync_tick)
          begin
            stm_d = stm_q + SYNC_W'(1);
            if (stm_d == scmp_q)
              evt[ST_CMP] = 1'b1;
          end
          if (stop_edge)
          begin
            ecnt_d = ecnt_q + EDG_CNT_W'(1);
            if (ecnt_d == edg_q[EDG_CNT_LSB +: EDG_CNT_W])
            begin
              evt[ST_STOP] = 1'b1;
              sst_d        = SY_IDLE;
            end
          end
        end
      endcase
      evt[ST_RISE] = rx_rise & ctl_q[CTL_SERIAL];
    end
    else
    begin
      brk_d     = '0;
      brk_hit_d = 1'b0;
      brk_ovf_d = 1'b0;
      sst_d     = SY_IDLE;
    end
    irq_evt          = evt;
    irq_evt[ST_RISE] = rx_rise & rise_en & ctl_q[CTL_EN] & ~rst_pend_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brk_q     <= '0;
      brk_hit_q <= 1'b0;
      brk_ovf_q <= 1'b0;
      stm_q     <= '0;
      ecnt_q    <= '0;
      sst_q     <= SY_IDLE;
    end
    else
    begin
      brk_q     <= brk_d;
      brk_hit_q <= brk_hit_d;
      brk_ovf_q <= brk_ovf_d;
      stm_q     <= stm_d;
      ecnt_q    <= ecnt_d;
      sst_q     <= sst_d;
    end
  end

  // Software registers, status and interrupt
  always_comb
  begin
    ctl_d      = ctl_q;
    edg_d      = edg_q;
    bcmp_d     = bcmp_q;
    scmp_d     = scmp_q;
    imsk_d     = imsk_q;
    rst_pend_d = 1'b0;
    // read clears, a new event still wins
    sta_d      = (rd_status ? '0 : sta_q) | evt;
    ist_d      = ist_q;
    if (do_write)
    begin
      unique case (wa_q)
        ADDR_SYNC_CTRL:
        begin
          ctl_d      = merge(ctl_q, wd_q, ws_q) & CTL_WR_MASK;
          rst_pend_d = ws_q[0] & wd_q[CTL_RST];
        end
        ADDR_EDGE_CTRL:     edg_d = merge(edg_q, wd_q, ws_q) & EDG_WR_MASK;
        ADDR_BREAK_COMPARE: bcmp_d = BRK_W'(merge({20'h0, bcmp_q}, wd_q, ws_q));
        ADDR_SYNC_COMPARE:  scmp_d = SYNC_W'(merge({16'h0, scmp_q}, wd_q, ws_q));
        ADDR_IRQ_STATUS:    ist_d = ist_q & ~(ws_q[0] ? wd_q[EVT_W-1:0] : '0);
        ADDR_IRQ_MASK:      imsk_d = ws_q[0] ? wd_q[EVT_W-1:0] : imsk_q;
        default: ;
      endcase
    end
    // events raise the interrupt, set beats clear
    ist_d = ist_d | irq_evt;
    irq_d = |(ist_d & imsk_d);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q      <= CTL_RESET;
      edg_q      <= EDG_RESET;
      bcmp_q     <= BRK_CMP_RESET;
      scmp_q     <= SYNC_CMP_RESET;
      sta_q      <= '0;
      ist_q      <= '0;
      imsk_q     <= '0;
      rst_pend_q <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      ctl_q      <= ctl_d;
      edg_q      <= edg_d;
      bcmp_q     <= bcmp_d;
      scmp_q     <= scmp_d;
      sta_q      <= sta_d;
      ist_q      <= ist_d;
      imsk_q     <= imsk_d;
      rst_pend_q <= rst_pend_d;
      irq_q      <= irq_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign irq     = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_READ_CLEARS: assert property (
    rd_status |=> sta_q == $past(evt))
    else $error("status not cleared by read");
  AST_RISE_SERIAL: assert property (
    $rose(sta_q[ST_RISE]) |-> $past(ctl_q[CTL_SERIAL]) && $past(rx_rise))
    else $error("rise flag outside bit-serial mode");
  AST_RESET_DONE: assert property (
    rst_pend_q |=> sta_q[ST_RST] && brk_q == '0 && stm_q == '0
                   && sst_q == SY_IDLE)
    else $error("unit reset incomplete");
  AST_BREAK_ERR: assert property (
    $rose(sta_q[ST_BERR]) |-> $past(brk_q) == BRK_MAX && ist_q[ST_BERR])
    else $error("break error without overflow");
  AST_SYNC_CMP: assert property (
    $rose(sta_q[ST_CMP]) |-> stm_q == scmp_q)
    else $error("compare flag without match");
  AST_STOP: assert property (
    $rose(sta_q[ST_STOP]) |-> $past(sst_q) == SY_COUNT && sst_q == SY_IDLE)
    else $error("stop flag outside measurement");
  AST_START: assert property (
    $rose(sta_q[ST_START]) |-> $past(sst_q) == SY_ARMED && sst_q == SY_COUNT)
    else $error("start flag outside armed state");
  AST_BREAK: assert property (
    $rose(sta_q[ST_BREAK]) |-> $past(brk_q) == $past(bcmp_q) && !$past(rx_lvl))
    else $error("break flag without compare");
  AST_WRITE_RESP: assert property (
    do_write |=> bvalid_q [*1] ##0 (aw_have_q == 1'b0))
    else $error("write response missing");

  COV_BREAK_SYNC: cover property (sta_q[ST_BREAK] ##[1:1000] sta_q[ST_STOP]);
  COV_BREAK_ERR:  cover property ($rose(sta_q[ST_BERR]));
  COV_RESET:      cover property (rst_pend_q ##1 sta_q[ST_RST]);
endmodule
`default_nettype wire

// File: bench/lin_master_model.sv
// Behavioural LIN master node: break, sync byte and short pulses
`timescale 1ns/1ps
`default_nettype none
module lin_master_model #(
  parameter int BIT_CLKS = 2000
) (
  // Clock
  input  wire logic aclk,
  // Bus level, recessive high
  output var  logic lin_rx
);
  // Pull-up on chip, so an idle bus reads high
  initial lin_rx = 1'h1;

  task automatic hold(input logic level, input int clks);
    @(posedge aclk);
    lin_rx <= level;
    repeat (clks - 1) @(posedge aclk);
  endtask

  // Break of whole bit times, then a one-bit delimiter
  task automatic send_break(input int bits);
    hold(1'h0, bits * BIT_CLKS);
    hold(1'h1, BIT_CLKS);
  endtask

  // Start bit, data LSB first, one stop bit
  task automatic send_byte(input logic [7:0] data);
    hold(1'h0, BIT_CLKS);
    for (int i = 0; i < 8; i++)
      hold(data[i], BIT_CLKS);
    hold(1'h1, BIT_CLKS);
  endtask

  task automatic pulse_low(input int clks);
    hold(1'h0, clks);
    hold(1'h1, 1);
  endtask
endmodule
`default_nettype wire

// File: bench/lin_hw_sync_test.sv
// Self-checking bench for the LIN break and sync timing unit
`timescale 1ns/1ps
`default_nettype none
module lin_hw_sync_test;
  import lin_sync_pkg::*;

  // Fastest bus rate keeps the run short
  localparam int BIT_CLKS = CLK_HZ / MAX_BAUD;
  localparam int SYNC_TICKS = 8 * BIT_CLKS / SYNC_DIV;
  localparam int RISE_TICKS = 7 * BIT_CLKS / SYNC_DIV;
  localparam int TIMEOUT = 90000;
  localparam logic [3:0] SERIAL_SEL = 4'h3;
  localparam logic [3:0] GATE_SEL = 4'h6;
  localparam logic [3:0] EXP_ST = 4'h3;
  localparam logic [3:0] EXP_IRQ = 4'h5;

  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0;
  logic        awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic [31:0] araddr = 32'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        awready;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        irq;
  wire logic   lin_rx;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;

  lin_hw_sync dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lin_rx(lin_rx), .irq(irq));

  lin_master_model #(.BIT_CLKS(BIT_CLKS)) master_u (.aclk(aclk),
    .lin_rx(lin_rx));

  always #12.5 aclk = ~aclk;

  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == TIMEOUT)
    begin
      failures++;
      $display("unexpected timeout expected %0d seen %0d", TIMEOUT, cycles);
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Both channels offered together, each released once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    logic aw_open;
    logic w_open;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw_open = 1'h1;
    w_open = 1'h1;
    forever
    begin
      @(posedge aclk);
      if (aw_open && awready === 1'h1)
      begin
        awvalid <= 1'h0;
        aw_open = 1'h0;
      end
      if (w_open && wready === 1'h1)
      begin
        wvalid <= 1'h0;
        w_open = 1'h0;
      end
      if (bvalid === 1'h1)
      begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        d = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'h0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(what, exp, d);
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic test_reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk("status reset", ADDR_SYNC_STATUS, STATUS_RESET);
    rd_chk("control reset", ADDR_SYNC_CTRL, CTL_RESET);
    rd_chk("edge control reset", ADDR_EDGE_CTRL, EDG_RESET);
    rd_chk("break cmp reset", ADDR_BREAK_COMPARE, {20'h0, BRK_CMP_RESET});
    rd_chk("sync cmp reset", ADDR_SYNC_COMPARE, {16'h0, SYNC_CMP_RESET});
    // Status is read-only: the write must leave it alone
    wr(ADDR_SYNC_STATUS, 32'h0000_007F);
    rd_chk("status after write", ADDR_SYNC_STATUS, 32'h0);
    axi_write(32'hFFFF_07A4, 32'h0000_0001, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(32'hFFFF_07A4, d, r);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    $display("test reset values done");
  endtask

  task automatic test_break_sync();
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_BREAK_COMPARE, 32'h0000_0050);
    wr(ADDR_SYNC_COMPARE, 32'h0000_03E8);
    wr(ADDR_SYNC_CTRL, 32'h0000_0001);
    master_u.send_break(13);
    // Start on first fall; the fourth fall after it stops the count
    master_u.send_byte(8'h55);
    rd_chk("status after sync", ADDR_SYNC_STATUS, 32'h0000_000F);
    rd_chk("status after read", ADDR_SYNC_STATUS, 32'h0);
    axi_read(ADDR_SYNC_TIMER, d, r);
    chk("sync timer near", 32'h1, {31'h0, d >= SYNC_TICKS - 2 && d <= SYNC_TICKS + 2});
    chk("irq while masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_000F);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd_chk("irq status", ADDR_IRQ_STATUS, 32'h0000_000F);
    wr(ADDR_IRQ_STATUS, 32'h0000_007F);
    repeat (2) @(posedge aclk);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rd_chk("irq status cleared", ADDR_IRQ_STATUS, 32'h0);
    $display("test break and sync done");
  endtask

  task automatic test_unit_reset();
    wr(ADDR_SYNC_CTRL, 32'h0000_0003);
    repeat (3) @(posedge aclk);
    rd_chk("sync timer cleared", ADDR_SYNC_TIMER, 32'h0);
    rd_chk("break timer cleared", ADDR_BREAK_TIMER, 32'h0);
    rd_chk("reset done flag", ADDR_SYNC_STATUS, 32'h0000_0020);
    rd_chk("reset flag cleared", ADDR_SYNC_STATUS, 32'h0);
    rd_chk("control after reset", ADDR_SYNC_CTRL, 32'h0000_0001);
    $display("test unit reset done");
  endtask

  // Every mode against both settings of the rise interrupt gate
  task automatic test_rise_gate();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_SYNC_CTRL, {19'h0, GATE_SEL[i], 9'h0, SERIAL_SEL[i], 2'h1});
      wr(ADDR_IRQ_MASK, 32'h0000_0040);
      wr(ADDR_IRQ_STATUS, 32'h0000_007F);
      axi_read(ADDR_SYNC_STATUS, d, r);
      master_u.pulse_low(40);
      repeat (4) @(posedge aclk);
      axi_read(ADDR_SYNC_STATUS, d, r);
      chk("status rise flag", {31'h0, EXP_ST[i]}, {31'h0, d[ST_RISE]});
      chk("irq on rise", {31'h0, EXP_IRQ[i]}, {31'h0, irq});
    end
    $display("test rise gate done");
  endtask

  // Rising stop edges: the fourth rise after the start fall ends the count
  task automatic test_edge_select();
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_EDGE_CTRL, 32'h0000_0042);
    // Short break against a low compare keeps the run short
    wr(ADDR_BREAK_COMPARE, 32'h0000_0008);
    master_u.send_break(2);
    master_u.send_byte(8'h55);
    rd_chk("status rise stop", ADDR_SYNC_STATUS, 32'h0000_000F);
    axi_read(ADDR_SYNC_TIMER, d, r);
    chk("sync timer rise stop", 32'h1,
        {31'h0, d >= RISE_TICKS - 2 && d <= RISE_TICKS + 2});
    $display("test edge select done");
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    test_reset_values();
    test_break_sync();
    test_unit_reset();
    test_rise_gate();
    test_edge_select();
    tally_and_finish();
  end
endmodule
`default_nettype wire
